// ===== design/linc_top.sv
// LIN master/slave controller with AXI4-Lite registers
// Assumes lin_rx/lin_tx go to a LIN transceiver, rx echoes tx
// Contract
// - Bit rate never above 20 kbit/s
// - One master, up to fifteen slaves
// - Master runs header and response tasks
// - Bytes framed start, eight data, stop
// - Master write sends header then response
// - Master read sends header, receives response
// - Slave sends or receives data and checksum
// - Detect break end, sync, full header
// - Programmable or measured automatic bit rate
// - Data length one to eight bytes
// - Classic or enhanced checksum selectable
// - Programmable break, delimiter and space widths
// - Identifier parity made and verified
// - Flag parity error on mismatch
// - Checksum generated, checked, error flagged
// - Break during response is response error
// - Received line glitch filtered
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`include "linc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module linc_top
  import linc_pkg::*;
#(
  parameter int CLK_HZ  = `LINC_CLK_HZ,
  parameter int MAX_BPS = `LINC_MAX_BPS,
  parameter int MIN_DIV = CLK_HZ / MAX_BPS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        lin_rx,
  output var  logic        lin_tx,
  output var  logic        irq
);
  localparam logic [15:0] DIV_MIN = 16'(MIN_DIV);

  // Register group
  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0]  waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [5:0]  ctrl_r, ctrl_nxt, id_r, id_nxt;
  logic [15:0] baud_r, baud_nxt;
  logic [3:0]  len_r, len_nxt;
  logic [27:0] space_r, space_nxt;
  logic [5:0]  stat_r, stat_nxt, mask_r, mask_nxt;
  logic        go_r, go_nxt, irq_r, irq_nxt;
  logic [7:0]  dat_r [8];
  logic [7:0]  dat_nxt [8];

  // Link group
  linc_state_t st_r, st_nxt;
  logic [2:0]  fl_r, fl_nxt;
  logic        filt_r, filt_nxt, filt_d_r, filt_d_nxt;
  logic [15:0] ltmr_r, ltmr_nxt, tmr_r, tmr_nxt;
  logic [3:0]  lbits_r, lbits_nxt, bitn_r, bitn_nxt;
  logic        act_r, act_nxt, arm_r, arm_nxt, btx_r, btx_nxt;
  logic [9:0]  shf_r, shf_nxt;
  logic [7:0]  rxs_r, rxs_nxt, sum_r, sum_nxt, pid_r, pid_nxt;
  logic [4:0]  gap_r, gap_nxt;
  logic [3:0]  idx_r, idx_nxt;
  logic        rtx_r, rtx_nxt, tx_r, tx_nxt;
  logic [5:0]  ev_r, ev_nxt;
  logic        rxw_r, rxw_nxt, abw_r, abw_nxt;
  logic [2:0]  rxi_r, rxi_nxt, edg_r, edg_nxt;
  logic [7:0]  rxd_r, rxd_nxt;
  logic [15:0] abd_r, abd_nxt;
  logic [19:0] meas_r, meas_nxt;

  // Link comb scratch
  logic        fall, rise, brk_end, bdone, gdone;
  logic        stx, srx, sgap;
  logic [7:0]  stx_b, cb;
  logic [4:0]  sgap_n;
  // Register comb scratch
  logic        do_wr, do_rd;
  logic [31:0] wm;

  function automatic logic [7:0] pid_of(input logic [5:0] i);
    logic id_parity_bit_high;
    logic id_parity_bit_low;
    id_parity_bit_low  = i[0] ^ i[1] ^ i[2] ^ i[4];
    id_parity_bit_high = ~(i[1] ^ i[3] ^ i[4] ^ i[5]);
    return {id_parity_bit_high, id_parity_bit_low, i};
  endfunction : pid_of

  // Carry wraps back into the sum
  function automatic logic [7:0] cks_add(input logic [7:0] a,
                                         input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[7:0] + {7'h00, t[8]};
  endfunction : cks_add

  function automatic logic [15:0] clamp_div(input logic [15:0] d);
    return (d < DIV_MIN) ? DIV_MIN : d;
  endfunction : clamp_div

  function automatic logic hit(input logic [7:0] a);
    return (a <= `LINC_A_DAT1) && (a[1:0] == 2'b00);
  endfunction : hit

  function automatic logic [31:0] rd_reg(input logic [7:0] a);
    unique case (a)
      `LINC_A_CTRL:  rd_reg = {26'h0, ctrl_r};
      `LINC_A_BAUD:  rd_reg = {16'h0, baud_r};
      `LINC_A_ID:    rd_reg = {16'h0, pid_r, 2'b00, id_r};
      `LINC_A_LEN:   rd_reg = {28'h0, len_r};
      `LINC_A_SPACE: rd_reg = {4'h0, space_r};
      `LINC_A_STAT:  rd_reg = {23'h0, st_r != S_IDLE, 2'b00, stat_r};
      `LINC_A_MASK:  rd_reg = {26'h0, mask_r};
      `LINC_A_DAT0:  rd_reg = {dat_r[3], dat_r[2], dat_r[1], dat_r[0]};
      `LINC_A_DAT1:  rd_reg = {dat_r[7], dat_r[6], dat_r[5], dat_r[4]};
      default:       rd_reg = 32'h0000_0000;
    endcase
  endfunction : rd_reg

  always_comb begin
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bresp_nxt   = bresp_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    ctrl_nxt    = ctrl_r;
    id_nxt      = id_r;
    len_nxt     = len_r;
    space_nxt   = space_r;
    mask_nxt    = mask_r;
    baud_nxt    = baud_r;
    dat_nxt     = dat_r;
    go_nxt      = 1'b0;
    aw_got_nxt  = aw_got_r | (s_axi_awvalid & awready_r);
    w_got_nxt   = w_got_r | (s_axi_wvalid & wready_r);
    if (s_axi_awvalid && awready_r) begin
      waddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    do_wr = aw_got_r & w_got_r & ~bvalid_r;
    wm = rd_reg(waddr_r);
    for (int k = 0; k < 4; k++) begin
      if (wstrb_r[k]) begin
        wm[8*k +: 8] = wdata_r[8*k +: 8];
      end
    end
    bvalid_nxt = bvalid_r & ~s_axi_bready;
    stat_nxt = stat_r;
    if (do_wr) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = hit(waddr_r) ? 2'b00 : 2'b10;
      unique case (waddr_r)
        `LINC_A_CTRL: begin
          ctrl_nxt = wm[5:0] & ~(6'h01 << `LINC_C_GO);
          go_nxt   = wm[`LINC_C_GO];
        end
        `LINC_A_BAUD:  baud_nxt = clamp_div(wm[15:0]);
        `LINC_A_ID:    id_nxt = wm[5:0];
        `LINC_A_LEN: begin
          len_nxt = (wm[3:0] == 4'h0) ? 4'h1 :
                    (wm[3:0] > `LINC_LEN_MAX) ? `LINC_LEN_MAX : wm[3:0];
        end
        `LINC_A_SPACE: space_nxt = wm[27:0];
        `LINC_A_STAT: begin
          stat_nxt = stat_r & ~(wdata_r[5:0] & {6{wstrb_r[0]}});
        end
        `LINC_A_MASK:  mask_nxt = wm[5:0];
        `LINC_A_DAT0: begin
          for (int k = 0; k < 4; k++) begin
            dat_nxt[k] = wm[8*k +: 8];
          end
        end
        `LINC_A_DAT1: begin
          for (int k = 0; k < 4; k++) begin
            dat_nxt[k+4] = wm[8*k +: 8];
          end
        end
        default: ;
      endcase
    end
    stat_nxt = stat_nxt | ev_r;
    if (abw_r) begin
      baud_nxt = clamp_div(abd_r);
    end
    if (rxw_r) begin
      dat_nxt[rxi_r] = rxd_r;
    end
    awready_nxt = ~aw_got_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_got_nxt & ~bvalid_nxt;
    do_rd = s_axi_arvalid & arready_r;
    rvalid_nxt = (rvalid_r & ~s_axi_rready) | do_rd;
    if (do_rd) begin
      rdata_nxt = rd_reg(s_axi_araddr);
      rresp_nxt = hit(s_axi_araddr) ? 2'b00 : 2'b10;
    end
    arready_nxt = ~rvalid_nxt;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      waddr_r   <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'b00;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= 2'b00;
      ctrl_r    <= `LINC_CTRL_RST;
      id_r      <= `LINC_ID_RST;
      baud_r    <= DIV_MIN;
      len_r     <= `LINC_LEN_RST;
      space_r   <= `LINC_SPACE_RST;
      stat_r    <= 6'h00;
      mask_r    <= `LINC_MASK_RST;
      go_r      <= 1'b0;
      irq_r     <= 1'b0;
      dat_r     <= '{default: 8'h00};
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      ctrl_r    <= ctrl_nxt;
      id_r      <= id_nxt;
      baud_r    <= baud_nxt;
      len_r     <= len_nxt;
      space_r   <= space_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      go_r      <= go_nxt;
      irq_r     <= irq_nxt;
      dat_r     <= dat_nxt;
    end
  end

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    bitn_nxt = bitn_r;
    act_nxt = act_r;
    arm_nxt = arm_r;
    btx_nxt = btx_r;
    shf_nxt = shf_r;
    rxs_nxt = rxs_r;
    sum_nxt = sum_r;
    pid_nxt = pid_r;
    gap_nxt = gap_r;
    idx_nxt = idx_r;
    rtx_nxt = rtx_r;
    tx_nxt = tx_r;
    edg_nxt = edg_r;
    meas_nxt = meas_r;
    ev_nxt = 6'h00;
    rxw_nxt = 1'b0;
    rxi_nxt = rxi_r;
    rxd_nxt = rxd_r;
    abw_nxt = 1'b0;
    abd_nxt = abd_r;
    stx = 1'b0;
    srx = 1'b0;
    sgap = 1'b0;
    stx_b = 8'h00;
    sgap_n = 5'h00;
    bdone = 1'b0;
    cb = 8'h00;
    fl_nxt = {fl_r[1:0], lin_rx};
    filt_nxt = (&fl_r) ? 1'b1 : (~|fl_r) ? 1'b0 : filt_r;
    filt_d_nxt = filt_r;
    fall = filt_d_r & ~filt_r;
    rise = ~filt_d_r & filt_r;
    ltmr_nxt = 16'h0000;
    lbits_nxt = 4'h0;
    if (!filt_r) begin
      ltmr_nxt = ltmr_r + 16'h0001;
      lbits_nxt = lbits_r;
      if (ltmr_r == baud_r - 16'h0001) begin
        ltmr_nxt = 16'h0000;
        if (lbits_r < `LINC_BRK_DET) begin
          lbits_nxt = lbits_r + 4'h1;
        end
      end
    end
    brk_end = rise && (lbits_r == `LINC_BRK_DET);
    if (arm_r && fall) begin
      arm_nxt = 1'b0;
      act_nxt = 1'b1;
      btx_nxt = 1'b0;
      bitn_nxt = 4'h0;
      tmr_nxt = 16'h0000;
    end else if (act_r) begin
      tmr_nxt = tmr_r + 16'h0001;
      if (tmr_r == (baud_r >> 1)) begin
        if (bitn_r != 4'h0 && bitn_r != 4'h9) begin
          rxs_nxt = {filt_r, rxs_r[7:1]};
        end
        // receive ends mid stop, keeps next start edge
        if (!btx_r && bitn_r == 4'h9) begin
          act_nxt = 1'b0;
          bdone = 1'b1;
        end
        if (btx_r && filt_r != tx_r) begin
          ev_nxt[`LINC_S_BUSE] = 1'b1;
        end
      end
      if (tmr_r == baud_r - 16'h0001) begin
        tmr_nxt = 16'h0000;
        bitn_nxt = bitn_r + 4'h1;
        shf_nxt = {1'b1, shf_r[9:1]};
        tx_nxt = btx_r ? shf_r[1] : 1'b1;
        if (bitn_r == 4'h9) begin
          act_nxt = 1'b0;
          bdone = 1'b1;
          tx_nxt = 1'b1;
        end
      end
    end else if (!arm_r) begin
      tmr_nxt = tmr_r + 16'h0001;
      if (tmr_r == baud_r - 16'h0001) begin
        tmr_nxt = 16'h0000;
        if (gap_r != 5'h00) begin
          gap_nxt = gap_r - 5'h01;
        end
      end
    end
    gdone = (gap_r == 5'h00);
    if (!ctrl_r[`LINC_C_EN]) begin
      st_nxt = S_IDLE;
      act_nxt = 1'b0;
      arm_nxt = 1'b0;
      tx_nxt = 1'b1;
    end else if (brk_end && st_r >= S_RSP && st_r <= S_CKS) begin
      ev_nxt[`LINC_S_RERR] = 1'b1;
      act_nxt = 1'b0;
      arm_nxt = 1'b0;
      tx_nxt = 1'b1;
      st_nxt = ctrl_r[`LINC_C_MST] ? S_IDLE : S_SYNC;
      edg_nxt = 3'h0;
      meas_nxt = 20'h00000;
      srx = ~ctrl_r[`LINC_C_MST] & ~ctrl_r[`LINC_C_ABD];
    end else begin
      unique case (st_r)
        S_IDLE: begin
          tx_nxt = 1'b1;
          if (ctrl_r[`LINC_C_MST] && go_r) begin
            st_nxt = S_BRK;
            tx_nxt = 1'b0;
            rtx_nxt = ctrl_r[`LINC_C_RTX];
            sgap = 1'b1;
            sgap_n = space_r[`LINC_SP_BRK +: 5];
          end else if (!ctrl_r[`LINC_C_MST] && brk_end) begin
            st_nxt = S_SYNC;
            rtx_nxt = ctrl_r[`LINC_C_RTX];
            edg_nxt = 3'h0;
            meas_nxt = 20'h00000;
            srx = ~ctrl_r[`LINC_C_ABD];
          end
        end
        S_BRK: begin
          if (gdone) begin
            st_nxt = S_DEL;
            tx_nxt = 1'b1;
            sgap = 1'b1;
            sgap_n = {1'b0, space_r[`LINC_SP_DEL +: 4]};
          end
        end
        S_DEL: begin
          if (gdone) begin
            st_nxt = S_SYNC;
            stx = 1'b1;
            stx_b = `LINC_SYNC_BYTE;
          end
        end
        S_SYNC: begin
          if (!ctrl_r[`LINC_C_MST] && ctrl_r[`LINC_C_ABD]) begin
            if (edg_r != 3'h0) begin
              meas_nxt = meas_r + 20'h00001;
            end
            if (fall) begin
              edg_nxt = edg_r + 3'h1;
              if (edg_r == 3'h4) begin
                abw_nxt = 1'b1;
                abd_nxt = meas_r[18:3];
                st_nxt = S_PID;
                srx = 1'b1;
              end
            end
          end else if (bdone) begin
            if (ctrl_r[`LINC_C_MST]) begin
              st_nxt = S_PID;
              stx = 1'b1;
              stx_b = pid_of(id_r);
            end else if (rxs_r == `LINC_SYNC_BYTE) begin
              st_nxt = S_PID;
              srx = 1'b1;
            end else begin
              st_nxt = S_IDLE;
            end
          end
        end
        S_PID: begin
          if (bdone) begin
            pid_nxt = rxs_r;
            if (rxs_r != pid_of(rxs_r[5:0])) begin
              ev_nxt[`LINC_S_PERR] = 1'b1;
              st_nxt = S_IDLE;
            end else if (ctrl_r[`LINC_C_MST] || rxs_r[5:0] == id_r) begin
              ev_nxt[`LINC_S_HDR] = 1'b1;
              st_nxt = S_RSP;
              idx_nxt = 4'h0;
              sum_nxt = ctrl_r[`LINC_C_ENH] ? rxs_r : 8'h00;
              sgap = 1'b1;
              sgap_n = {1'b0, space_r[`LINC_SP_RSP +: 4]};
            end else begin
              ev_nxt[`LINC_S_HDR] = 1'b1;
              st_nxt = S_IDLE;
            end
          end
        end
        S_RSP: begin
          if (gdone) begin
            st_nxt = S_DATA;
            stx = rtx_r;
            srx = ~rtx_r;
            stx_b = dat_r[idx_r[2:0]];
          end
        end
        S_DATA: begin
          if (bdone) begin
            cb = rtx_r ? dat_r[idx_r[2:0]] : rxs_r;
            sum_nxt = cks_add(sum_r, cb);
            rxw_nxt = ~rtx_r;
            rxi_nxt = idx_r[2:0];
            rxd_nxt = rxs_r;
            idx_nxt = idx_r + 4'h1;
            st_nxt = S_IBS;
            sgap = 1'b1;
            sgap_n = {1'b0, space_r[`LINC_SP_IBS +: 4]};
          end
        end
        S_IBS: begin
          if (gdone) begin
            st_nxt = (idx_r == len_r) ? S_CKS : S_DATA;
            stx = rtx_r;
            srx = ~rtx_r;
            stx_b = (idx_r == len_r) ? ~sum_r : dat_r[idx_r[2:0]];
          end
        end
        S_CKS: begin
          if (bdone) begin
            if (!rtx_r && cks_add(sum_r, rxs_r) != `LINC_CKS_OK) begin
              ev_nxt[`LINC_S_CERR] = 1'b1;
            end
            ev_nxt[`LINC_S_DONE] = 1'b1;
            st_nxt = S_IFS;
            sgap = 1'b1;
            sgap_n = {1'b0, space_r[`LINC_SP_IFS +: 4]};
          end
        end
        S_IFS: begin
          if (gdone) begin
            st_nxt = S_IDLE;
          end
        end
        default: st_nxt = S_IDLE;
      endcase
    end
    if (stx) begin
      act_nxt = 1'b1;
      btx_nxt = 1'b1;
      bitn_nxt = 4'h0;
      tmr_nxt = 16'h0000;
      shf_nxt = {1'b1, stx_b, 1'b0};
      tx_nxt = 1'b0;
    end
    if (srx) begin
      arm_nxt = 1'b1;
    end
    if (sgap) begin
      gap_nxt = sgap_n;
      tmr_nxt = 16'h0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= S_IDLE;
      fl_r <= 3'h7;
      filt_r <= 1'b1;
      filt_d_r <= 1'b1;
      ltmr_r <= 16'h0000;
      lbits_r <= 4'h0;
      tmr_r <= 16'h0000;
      bitn_r <= 4'h0;
      act_r <= 1'b0;
      arm_r <= 1'b0;
      btx_r <= 1'b0;
      shf_r <= 10'h3ff;
      rxs_r <= 8'h00;
      sum_r <= 8'h00;
      pid_r <= 8'h00;
      gap_r <= 5'h00;
      idx_r <= 4'h0;
      rtx_r <= 1'b0;
      tx_r <= 1'b1;
      ev_r <= 6'h00;
      rxw_r <= 1'b0;
      rxi_r <= 3'h0;
      rxd_r <= 8'h00;
      abw_r <= 1'b0;
      abd_r <= 16'h0000;
      edg_r <= 3'h0;
      meas_r <= 20'h00000;
    end else begin
      st_r <= st_nxt;
      fl_r <= fl_nxt;
      filt_r <= filt_nxt;
      filt_d_r <= filt_d_nxt;
      ltmr_r <= ltmr_nxt;
      lbits_r <= lbits_nxt;
      tmr_r <= tmr_nxt;
      bitn_r <= bitn_nxt;
      act_r <= act_nxt;
      arm_r <= arm_nxt;
      btx_r <= btx_nxt;
      shf_r <= shf_nxt;
      rxs_r <= rxs_nxt;
      sum_r <= sum_nxt;
      pid_r <= pid_nxt;
      gap_r <= gap_nxt;
      idx_r <= idx_nxt;
      rtx_r <= rtx_nxt;
      tx_r <= tx_nxt;
      ev_r <= ev_nxt;
      rxw_r <= rxw_nxt;
      rxi_r <= rxi_nxt;
      rxd_r <= rxd_nxt;
      abw_r <= abw_nxt;
      abd_r <= abd_nxt;
      edg_r <= edg_nxt;
      meas_r <= meas_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign lin_tx        = tx_r;
  assign irq           = irq_r;
endmodule : linc_top
`default_nettype wire

// ===== design/linc_defs.svh
// Register map, field positions, reset values and timing figures
// Assumes a 32-bit AXI4-Lite slave with byte addresses
`ifndef LINC_DEFS_SVH
`define LINC_DEFS_SVH
`define LINC_A_CTRL     8'h00
`define LINC_A_BAUD     8'h04
`define LINC_A_ID       8'h08
`define LINC_A_LEN      8'h0c
`define LINC_A_SPACE    8'h10
`define LINC_A_STAT     8'h14
`define LINC_A_MASK     8'h18
`define LINC_A_DAT0     8'h1c
`define LINC_A_DAT1     8'h20
`define LINC_C_EN       0
`define LINC_C_MST      1
`define LINC_C_ENH      2
`define LINC_C_RTX      3
`define LINC_C_GO       4
`define LINC_C_ABD      5
`define LINC_S_DONE     0
`define LINC_S_BUSE     1
`define LINC_S_PERR     2
`define LINC_S_CERR     3
`define LINC_S_RERR     4
`define LINC_S_HDR      5
`define LINC_S_BUSY     8
`define LINC_SP_BRK     0
`define LINC_SP_DEL     8
`define LINC_SP_RSP     16
`define LINC_SP_IBS     20
`define LINC_SP_IFS     24
`define LINC_CTRL_RST   6'h00
`define LINC_ID_RST     6'h00
`define LINC_LEN_RST    4'h8
`define LINC_LEN_MAX    4'h8
`define LINC_SPACE_RST  28'h201010d
`define LINC_MASK_RST   6'h00
`define LINC_BRK_DET    4'hb
`define LINC_SYNC_BYTE  8'h55
`define LINC_CKS_OK     8'hff
`define LINC_CLK_HZ     125000000
`define LINC_MAX_BPS    20000
`endif

// ===== design/linc_pkg.sv
// Types shared by the LIN controller
// Used with linc_defs.svh
package linc_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_BRK  = 4'b0001,
    S_DEL  = 4'b0010,
    S_SYNC = 4'b0011,
    S_PID  = 4'b0100,
    S_RSP  = 4'b0101,
    S_DATA = 4'b0110,
    S_IBS  = 4'b0111,
    S_CKS  = 4'b1000,
    S_IFS  = 4'b1001
  } linc_state_t;
endpackage : linc_pkg

// ===== testbench/lmsc_sva.sv
// Bus and line checks on the controller's ports
// Bound to linc_top, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module lmsc_sva #(
  parameter int MIN_DIV = 16
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        lin_rx,
  input wire logic        lin_tx,
  input wire logic        irq
);
  int low_n;
  wire logic bad_w = s_axi_awaddr > 8'h20 || |s_axi_awaddr[1:0];
  wire logic bad_r = s_axi_araddr > 8'h20 || |s_axi_araddr[1:0];
  // Run length of a dominant level driven on lin_tx
  always_ff @(posedge aclk) begin
    low_n <= (!aresetn || lin_tx) ? 0 : low_n + 1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rst_idle: assert property (disable iff (1'b0)
    !aresetn |=> !irq && lin_tx && !s_axi_bvalid) else $error("reset idle");
  a_bit_low_run: assert property (
    $rose(lin_tx) |-> low_n >= MIN_DIV) else $error("short low bit");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
  a_wr_resp: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid &&
    s_axi_bresp == ($past(bad_w, 2) ? 2'b10 : 2'b00)) else $error("bresp");
  a_rd_resp: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rresp == ($past(bad_r) ? 2'b10 : 2'b00))
    else $error("rresp");
  a_w_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not held");
  a_r_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read not held");
endmodule : lmsc_sva
bind linc_top lmsc_sva #(.MIN_DIV(MIN_DIV)) u_sva (.*);
`default_nettype wire

// ===== testbench/lmsc_node.sv
// Far LIN node: byte capture off the bus, slave answers on demand
// Bus is wired-AND with a pull-up, so idle tx is recessive
`timescale 1ns/1ps
`default_nettype none
module lmsc_node #(
  parameter int B = 16
) (
  input wire logic clk,
  input wire logic bus,
  output logic     tx
);
  logic [7:0] q[$];
  logic [7:0] d;
  initial tx = 1'b1;
  always begin
    @(negedge bus);
    repeat (B / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (B) @(posedge clk);
      d[i] = bus;
    end
    repeat (B) @(posedge clk);
    // Break has a low stop bit, so it is dropped
    if (bus) q.push_back(d);
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx <= f[i];
      repeat (B) @(posedge clk);
    end
  endtask : send
endmodule : lmsc_node
`default_nettype wire

// ===== testbench/lin_master_slave_controller_test.sv
// Register and frame tests of the LIN controller
// Short divisor; far node on a wired-AND line
`timescale 1ns/1ps
`default_nettype none
module lin_master_slave_controller_test;
  localparam int B = 16;
  localparam logic [5:0] ID = 6'h3a;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pid, ex;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, lin_tx, irq, node_tx;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [8:0] sm;
  wire logic lin_rx = lin_tx & node_tx;
  int err_total = 0, num_checks = 0;
  linc_top #(.MIN_DIV(B)) u_dut (.*);
  lmsc_node #(.B(B)) u_node (.clk(aclk), .bus(lin_rx), .tx(node_tx));
  always #4 aclk = ~aclk;
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta = 0, tw = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      ta |= s_axi_awready;
      tw |= s_axi_wready;
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end while (!(ta && tw));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    chk(rv & m, e);
  endtask : rc
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // Frames take about a thousand cycles each
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  initial begin
    pid = {~(ID[1] ^ ID[3] ^ ID[4] ^ ID[5]), ^{ID[0], ID[1], ID[2], ID[4]}, ID};
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rc(8'h10, 32'hfffffff, 32'h201010d);
    wr(8'h04, 3);
    rc(8'h04, 32'hffff, B);
    rc(8'h24, 0, 0);
    chk(rr, 2'b10);
    wr(8'h0c, 9);
    rc(8'h0c, 32'hf, 8);
    wr(8'h0c, 0);
    rc(8'h0c, 32'hf, 1);
    wr(8'h1c, 8'ha5);
    wr(8'h08, ID);
    wr(8'h18, 6'h09);
    for (int e = 0; e < 2; e++) begin
      u_node.q.delete();
      wr(8'h00, 32'h1b | (e << 2));
      do @(posedge aclk); while (!irq);
      sm = 9'ha5 + (e ? pid : 8'h0);
      ex = ~(sm[7:0] + sm[8]);
      chk(u_node.q.size(), 4);
      chk(u_node.q[0], 8'h55);
      chk(u_node.q[1], pid);
      chk(u_node.q[2], 8'ha5);
      chk(u_node.q[3], ex);
      rc(8'h14, 32'h3f, 32'h21);
      wr(8'h14, 32'h3f);
      repeat (2) @(posedge aclk);
      chk(irq, 0);
      repeat (3 * B) @(posedge aclk);
      rc(8'h14, 32'h13f, 0);
    end
    for (int b = 0; b < 2; b++) begin
      u_node.q.delete();
      wr(8'h00, 32'h13);
      do @(posedge aclk); while (u_node.q.size() < 2);
      repeat (2 * B) @(posedge aclk);
      u_node.send(8'h5a);
      u_node.send(b ? 8'h00 : 8'ha5);
      do @(posedge aclk); while (!irq);
      rc(8'h14, 32'h8, b << 3);
      if (!b) rc(8'h1c, 32'hff, 8'h5a);
      wr(8'h14, 32'h3f);
      repeat (3 * B) @(posedge aclk);
      rc(8'h14, 32'h13f, 0);
    end
    wrap_up();
  end
endmodule : lin_master_slave_controller_test
`default_nettype wire
